// *** core/eeprom_loader_pkg.sv ***
// constants, states and carriers of the serial eeprom loader
// assumes a 100 MHz system clock and a pulled-up two-wire data line
package eeprom_loader_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_KHZ = 100000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_MAX_KHZ = 100;
	// four quarters per serial clock period, rounded up so the rate never exceeds the maximum
	localparam int QUARTER_CYCLES = (CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
	localparam int BUS_FREE_NS = 4700;
	localparam int BUS_FREE_CYCLES = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] QUARTER_LAST = CNT_W'(QUARTER_CYCLES - 1);
	localparam logic [CNT_W-1:0] FREE_LAST = CNT_W'(BUS_FREE_CYCLES - 1);

	// ****************************************
	// two-wire framing and image layout
	// ****************************************
	localparam logic [7:0] DEV_ADDR_WR = 8'ha0;
	localparam logic [7:0] DEV_ADDR_RD = 8'ha1;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int LOAD_BYTES = 16;
	localparam int IDX_W = 4;
	localparam logic [IDX_W-1:0] LOAD_LAST = IDX_W'(LOAD_BYTES - 1);
	localparam int OFS_FORMAT = 0;
	localparam int OFS_UID_FIRST = 1;
	localparam int UID_BYTES = 8;
	localparam int OFS_OPTROM = 9;
	localparam int OFS_CIS = 10;
	localparam int OPTROM_W = 6;
	localparam logic [7:0] FMT_BASIC = 8'h00;
	localparam logic [7:0] FMT_CARDBUS = 8'h01;
	localparam logic [7:0] FMT_UID_ONLY = 8'h02;
	localparam logic [7:0] CACHE_RESET = 8'h00;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_TX = 3'h3,
		ST_RX = 3'h2,
		ST_STOP = 3'h6,
		ST_FREE = 3'h7
	} link_state_e;

	typedef enum logic [1:0] {
		IMG_BASIC = 2'h0,
		IMG_CARDBUS = 2'h1,
		IMG_UID_ONLY = 2'h2,
		IMG_UNKNOWN = 2'h3
	} image_format_e;

	typedef struct packed {
		logic loading;
		logic done;
		logic fail;
		logic absent;
	} load_status_s;

	localparam load_status_s STATUS_RESET = '{loading: 1'b0, done: 1'b0, fail: 1'b0, absent: 1'b0};

endpackage

// *** core/serial_eeprom_loader.sv ***
// two-wire eeprom loader: power-up image load plus single-byte software reads
// assumes sda is pulled up outside, eeprom answers at the fixed device address,
// and the power-on reset is released no later than the first bus reset
//
// What this block does
// - act as master of two-wire eeprom link
// - always drive the serial clock ourselves
// - drive data only during our own bits
// - load eeprom after first reset following power-up
// - soft reset or wake never reloads eeprom
// - software starts eeprom reads, gets data back
// - retry register accesses while load runs
// - flag load failure, detect missing eeprom quickly
// - update option rom offset field after load
// - accept several image layouts, including cardbus
// - serial clock at most 100 kHz
// - bus idle 4.7 us after stop
`timescale 1ns/1ps
module serial_eeprom_loader (
	input wire logic sys_clk_in, // system clock, 100 MHz
	input wire logic reset_n_in, // bus reset, active low, async
	input wire logic por_n_in, // power-on reset, active low, async
	input wire logic ce_in, // clock enable, freezes all state except the reset synchronisers when low
	input wire logic sw_read_req_in, // software read request
	input wire logic [7:0] sw_word_addr_in, // eeprom word address to read
	output logic sw_busy_out, // software read in progress or refused
	output logic sw_done_out, // one-cycle read completion
	output logic sw_nack_out, // last software read was not acknowledged
	output logic [7:0] sw_read_data_out, // byte returned by last read
	output logic access_retry_out, // answer register accesses with retry
	output eeprom_loader_pkg::load_status_s load_status_out, // load status flags
	output eeprom_loader_pkg::image_format_e image_format_out, // decoded layout
	output logic [63:0] node_unique_identifier_out, // identifier from image
	output logic [eeprom_loader_pkg::OPTROM_W-1:0] option_rom_offset_field_out, // option rom
	output logic [7:0] card_info_structure_out, // cardbus info pointer
	output logic scl_out, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data pin drive value
	output logic sda_oe_out // serial data drive enable
);
	import eeprom_loader_pkg::*;

	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic rst_meta, rst_n, por_meta, por_n, sda_meta, sda_s;

	// bus reset released through two flops
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// power-on reset released the same way
	always_ff @(posedge sys_clk_in or negedge por_n_in) begin
		if (!por_n_in) begin
			por_meta <= 1'b0;
			por_n <= 1'b0;
		end else begin
			por_meta <= 1'b1;
			por_n <= por_meta;
		end
	end

	// data pin comes from outside our domain
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
		end else if (ce_in) begin
			sda_meta <= sda_in;
			sda_s <= sda_meta;
		end
	end

	// ****************************************
	// link sequencer
	// ****************************************
	link_state_e state, next_state;
	logic [1:0] q, next_q;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] sh, next_sh, word_addr, next_word_addr, sw_data, next_sw_data;
	logic [1:0] phase, next_phase;
	logic [IDX_W-1:0] idx, next_idx;
	logic load_mode, next_load_mode, nack, next_nack, err, next_err;
	logic sw_done, next_sw_done, sw_nack, next_sw_nack;
	logic scl, next_scl, sda_low, next_sda_low, start_load;
	load_status_s status, next_status;
	logic loaded_once, next_loaded_once;
	logic cache_we;
	logic [7:0] cache [LOAD_BYTES];
	logic quarter_end, last_byte, fmt_ok;

	assign quarter_end = (cnt == QUARTER_LAST);
	assign last_byte = !load_mode || (idx == LOAD_LAST);
	assign fmt_ok = (cache[OFS_FORMAT] == FMT_BASIC) || (cache[OFS_FORMAT] == FMT_CARDBUS) ||
		(cache[OFS_FORMAT] == FMT_UID_ONLY);

	// next values of the sequencer, pins follow state and quarter
	always_comb begin
		next_state = state;
		next_q = q;
		next_cnt = cnt;
		next_bit_cnt = bit_cnt;
		next_sh = sh;
		next_word_addr = word_addr;
		next_sw_data = sw_data;
		next_phase = phase;
		next_idx = idx;
		next_load_mode = load_mode;
		next_nack = nack;
		next_err = err;
		next_sw_done = 1'b0;
		next_sw_nack = sw_nack;
		next_status = status;
		start_load = 1'b0;
		cache_we = 1'b0;
		next_scl = 1'b1;
		next_sda_low = 1'b0;
		if (state != ST_IDLE && state != ST_FREE) begin
			next_cnt = quarter_end ? '0 : cnt + 1'b1;
			if (quarter_end) begin
				next_q = q + 1'b1;
			end
		end
		unique case (state)
			ST_IDLE: begin
				next_cnt = '0;
				next_q = 2'h0;
				next_phase = 2'h0;
				next_idx = '0;
				next_err = 1'b0;
				if (!loaded_once && !por_n) begin
					// a power-on reset that outlasts the bus reset holds the load back
					next_state = ST_IDLE;
				end else if (!loaded_once) begin
					// only power-on clears the flag, so later resets never reload
					start_load = 1'b1;
					next_load_mode = 1'b1;
					next_word_addr = 8'h00;
					next_status = '{loading: 1'b1, done: 1'b0, fail: 1'b0, absent: 1'b0};
					next_state = ST_START;
				end else if (sw_read_req_in) begin
					next_load_mode = 1'b0;
					next_word_addr = sw_word_addr_in;
					next_state = ST_START;
				end
			end
			ST_START: begin
				// sda falls while scl high, then scl falls
				next_scl = (q == 2'h1) || (q == 2'h2);
				next_sda_low = q[1];
				if (quarter_end && q == 2'h3) begin
					next_state = ST_TX;
					next_bit_cnt = 4'h0;
					next_sh = (phase == 2'h2) ? DEV_ADDR_RD : DEV_ADDR_WR;
				end
			end
			ST_TX: begin
				next_scl = (q == 2'h1) || (q == 2'h2);
				// release the line for the eeprom acknowledge
				next_sda_low = (bit_cnt != ACK_BIT) && !sh[7];
				if (quarter_end && q == 2'h1 && bit_cnt == ACK_BIT) begin
					next_nack = sda_s;
				end
				if (quarter_end && q == 2'h3) begin
					if (bit_cnt != ACK_BIT) begin
						next_sh = {sh[6:0], 1'b0};
						next_bit_cnt = bit_cnt + 1'b1;
					end else if (nack) begin
						// a silent first address byte means nothing is fitted
						next_err = 1'b1;
						if (load_mode && phase == 2'h0) begin
							next_status.absent = 1'b1;
							next_status.fail = 1'b1; // absent never shows without fail
						end
						next_state = ST_STOP;
					end else begin
						next_bit_cnt = 4'h0;
						next_phase = phase + 1'b1;
						unique case (phase)
							2'h0: next_sh = word_addr;
							2'h1: next_state = ST_START;
							default: next_state = ST_RX;
						endcase
					end
				end
			end
			ST_RX: begin
				next_scl = (q == 2'h1) || (q == 2'h2);
				// master acknowledges every byte except the last
				next_sda_low = (bit_cnt == ACK_BIT) && !last_byte;
				if (quarter_end && q == 2'h1 && bit_cnt != ACK_BIT) begin
					next_sh = {sh[6:0], sda_s};
				end
				if (quarter_end && q == 2'h3) begin
					if (bit_cnt != ACK_BIT) begin
						next_bit_cnt = bit_cnt + 1'b1;
					end else begin
						cache_we = load_mode;
						next_bit_cnt = 4'h0;
						if (last_byte) begin
							next_state = ST_STOP;
						end else begin
							next_idx = idx + 1'b1;
						end
					end
				end
			end
			ST_STOP: begin
				next_scl = (q != 2'h0);
				next_sda_low = !q[1];
				if (quarter_end && q == 2'h3) begin
					next_state = ST_FREE;
					next_cnt = '0;
					if (load_mode) begin
						next_status.loading = 1'b0;
						next_status.done = 1'b1;
						next_status.fail = err || !fmt_ok;
					end else begin
						next_sw_done = 1'b1;
						next_sw_nack = err;
						next_sw_data = err ? 8'hff : sh;
					end
				end
			end
			ST_FREE: begin
				next_cnt = cnt + 1'b1;
				if (cnt == FREE_LAST) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_loaded_once = loaded_once || start_load;
	end

	// sequencer registers
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			q <= 2'h0;
			cnt <= '0;
			bit_cnt <= 4'h0;
			sh <= 8'h00;
			word_addr <= 8'h00;
			sw_data <= 8'h00;
			phase <= 2'h0;
			idx <= '0;
			load_mode <= 1'b0;
			nack <= 1'b0;
			err <= 1'b0;
			sw_done <= 1'b0;
			sw_nack <= 1'b0;
			scl <= 1'b1;
			sda_low <= 1'b0;
			status <= STATUS_RESET;
		end else if (ce_in) begin
			state <= next_state;
			q <= next_q;
			cnt <= next_cnt;
			bit_cnt <= next_bit_cnt;
			sh <= next_sh;
			word_addr <= next_word_addr;
			sw_data <= next_sw_data;
			phase <= next_phase;
			idx <= next_idx;
			load_mode <= next_load_mode;
			nack <= next_nack;
			err <= next_err;
			sw_done <= next_sw_done;
			sw_nack <= next_sw_nack;
			scl <= next_scl;
			sda_low <= next_sda_low;
			status <= next_status;
		end
	end

	// survives bus resets, cleared only at power-on
	always_ff @(posedge sys_clk_in or negedge por_n) begin
		if (!por_n) begin
			loaded_once <= 1'b0;
		end else if (ce_in && rst_n) begin
			// held while the bus reset is applied, else the load would be skipped
			loaded_once <= next_loaded_once;
		end
	end

	// ****************************************
	// image cache and decode
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < LOAD_BYTES; gi++) begin : g_cache
			// one byte per entry, written as the load streams past
			always_ff @(posedge sys_clk_in or negedge rst_n) begin
				if (!rst_n) begin
					cache[gi] <= CACHE_RESET;
				end else if (ce_in && cache_we && idx == IDX_W'(gi)) begin
					cache[gi] <= sh;
				end
			end
		end
	endgenerate

	image_format_e fmt, next_fmt;
	logic [63:0] uid, next_uid;
	logic [OPTROM_W-1:0] optrom, next_optrom;
	logic [7:0] card_info_structure, next_cis;

	// layout decides which fields are valid; invalid ones read as zero
	always_comb begin
		next_uid = '0;
		for (int i = 0; i < UID_BYTES; i++) begin
			next_uid[63-8*i -: 8] = cache[OFS_UID_FIRST+i];
		end
		next_optrom = cache[OFS_OPTROM][OPTROM_W-1:0];
		next_cis = 8'h00;
		if (cache[OFS_FORMAT] == FMT_BASIC) begin
			next_fmt = IMG_BASIC;
		end else if (cache[OFS_FORMAT] == FMT_CARDBUS) begin
			next_fmt = IMG_CARDBUS;
			next_cis = cache[OFS_CIS];
		end else if (cache[OFS_FORMAT] == FMT_UID_ONLY) begin
			next_fmt = IMG_UID_ONLY;
			next_optrom = '0;
		end else begin
			next_fmt = IMG_UNKNOWN;
			next_optrom = '0;
		end
		if (!status.done || status.fail) begin
			next_uid = '0;
			next_optrom = '0;
			next_cis = 8'h00;
		end
	end

	// decoded fields held in flops
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fmt <= IMG_BASIC;
			uid <= '0;
			optrom <= '0;
			card_info_structure <= 8'h00;
		end else if (ce_in) begin
			fmt <= next_fmt;
			uid <= next_uid;
			optrom <= next_optrom;
			card_info_structure <= next_cis;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open-drain style: the line is only ever pulled low, never driven high
	assign scl_out = scl;
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_low;
	assign access_retry_out = status.loading || !loaded_once;
	assign sw_busy_out = (state != ST_IDLE) || !loaded_once;
	assign sw_done_out = sw_done;
	assign sw_nack_out = sw_nack;
	assign sw_read_data_out = sw_data;
	assign load_status_out = status;
	assign image_format_out = fmt;
	assign node_unique_identifier_out = uid;
	assign option_rom_offset_field_out = optrom;
	assign card_info_structure_out = card_info_structure;

endmodule // serial_eeprom_loader

// *** test/loader_asserts.sv ***
// port checker for the eeprom loader
// assumes it is bound onto serial_eeprom_loader
`timescale 1ns/1ps
module loader_asserts (
	input wire logic sys_clk_in, // clock
	input wire logic reset_n_in, // reset, active low
	input wire logic sw_busy_out, // read busy
	input wire logic sw_done_out, // read done
	input wire logic access_retry_out, // retry
	input eeprom_loader_pkg::load_status_s load_status_out, // status
	input wire logic [63:0] node_unique_identifier_out, // identifier
	input wire logic [eeprom_loader_pkg::OPTROM_W-1:0] option_rom_offset_field_out, // rom
	input wire logic scl_out, // serial clock
	input wire logic sda_out, // data value
	input wire logic sda_oe_out // data enable
);
	import eeprom_loader_pkg::*;
	// ****
	// helpers
	// ****
	logic [9:0] free_cnt;
	logic [9:0] rise_cnt;
	logic scl_q;
	logic oe_q;
	// saturating counters, so a long idle never wraps into a false failure
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			free_cnt <= '1;
			rise_cnt <= '1;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			free_cnt <= (oe_q && !sda_oe_out && scl_out && scl_q) ? '0 : free_cnt + 10'(free_cnt != '1);
			rise_cnt <= (scl_out && !scl_q) ? '0 : rise_cnt + 10'(rise_cnt != '1);
			scl_q <= scl_out;
			oe_q <= sda_oe_out;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	scl_rate_a: assert property ((scl_out && !scl_q) |-> rise_cnt >= 10'd999)
		else $error("serial clock too fast");
	bus_free_a: assert property ((sda_oe_out && !oe_q && scl_out && scl_q) |-> free_cnt >= 10'd469)
		else $error("start too soon after stop");
	retry_load_a: assert property (load_status_out.loading |-> access_retry_out)
		else $error("no retry while loading");
	busy_retry_a: assert property (access_retry_out |-> sw_busy_out)
		else $error("software read open during load");
	done_pulse_a: assert property (sw_done_out |=> !sw_done_out)
		else $error("done longer than one cycle");
	absent_fail_a: assert property (load_status_out.absent |-> load_status_out.fail)
		else $error("absent without fail");
	fields_gate_a: assert property (!load_status_out.done |-> node_unique_identifier_out == 64'h0 && option_rom_offset_field_out == '0)
		else $error("fields shown before load");
	no_reload_a: assert property (load_status_out.done |=> !load_status_out.loading)
		else $error("second load started");
	idle_lines_a: assert property (!sw_busy_out |-> scl_out && !sda_oe_out)
		else $error("lines not idle");
endmodule // loader_asserts

// *** test/eeprom_model.sv ***
// behavioural two-wire eeprom answering random reads
// assumes an open-drain line resolved by the bench
`timescale 1ns/1ps
module eeprom_model (
	input wire logic scl_in, // serial clock
	input wire logic sda_in, // resolved data line
	input wire logic present_in, // low models an empty socket
	output logic pull_out // high pulls the line low
);
	import eeprom_loader_pkg::*;
	// ****
	// slave
	// ****
	logic [7:0] mem [256];
	logic [7:0] shift;
	logic [7:0] ptr;
	int bitn;
	logic act;
	logic rd;
	logic go_rd;
	logic first;
	initial begin
		pull_out = 0;
		act = 0;
		rd = 0;
		for (int a = 0; a < 256; a++) mem[a] = 8'(a * 17 + 1);
	end
	// start or repeated start rearms the byte framing
	always @(negedge sda_in) if (scl_in) begin
		act = 1;
		rd = 0;
		go_rd = 0;
		first = 1;
		bitn = 0;
	end
	always @(posedge sda_in) if (scl_in) act = 0; // stop
	// sample on rising clock; a master nack ends the burst
	always @(posedge scl_in) if (act) begin
		if (rd && bitn == 8) begin
			ptr = ptr + 8'h01;
			if (sda_in) act = 0;
		end else if (!rd && bitn < 8) shift = {shift[6:0], sda_in};
		if (bitn == 8) rd = go_rd;
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end
	// drive only in our own slots, changing while the clock is low
	always @(negedge scl_in) begin
		pull_out = 0;
		if (act && !rd && bitn == 8 && present_in && (!first || shift[7:1] == DEV_ADDR_WR[7:1])) begin
			pull_out = 1;
			if (first) go_rd = (shift == DEV_ADDR_RD);
			else ptr = shift;
			first = 0;
		end else if (act && rd && bitn < 8) pull_out = !mem[ptr][7 - bitn];
	end
endmodule // eeprom_model

// *** test/testbench.sv ***
// top bench: power-up load, software reads, bus reset, empty socket
// assumes the eeprom model and checker files compile first
`timescale 1ns/1ps
module testbench;
	import eeprom_loader_pkg::*;
	// ****
	// bench
	// ****
	typedef struct packed {logic [7:0] addr; logic nack;} row_s;
	logic sys_clk_in = 0, reset_n_in = 0, por_n_in = 0, ce_in = 1, req = 0, present = 1;
	logic [7:0] waddr = 8'h00;
	logic busy, done, nack, retry, scl, sda_o, sda_oe, pull;
	logic [7:0] rdata, card_info_structure;
	logic [63:0] uid, exp_uid;
	logic [OPTROM_W-1:0] optrom;
	load_status_s st;
	image_format_e fmt;
	logic [2:0] flags;
	wire sda = !(sda_oe || pull); // pulled-up line
	int error_cnt = 0, n_compared = 0, i;
	row_s rows [2] = '{'{8'h05, 1'b0}, '{8'hff, 1'b0}};
	assign flags = {st.done, done, busy};
	initial forever #5 sys_clk_in = ~sys_clk_in;
	serial_eeprom_loader uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.por_n_in(por_n_in), .ce_in(ce_in), .sw_read_req_in(req), .sw_word_addr_in(waddr),
		.sw_busy_out(busy), .sw_done_out(done), .sw_nack_out(nack), .sw_read_data_out(rdata),
		.access_retry_out(retry), .load_status_out(st), .image_format_out(fmt),
		.node_unique_identifier_out(uid), .option_rom_offset_field_out(optrom),
		.card_info_structure_out(card_info_structure), .scl_out(scl), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_out(sda_oe));
	eeprom_model ee (.scl_in(scl), .sda_in(sda), .present_in(present), .pull_out(pull));
	function automatic logic [7:0] img(int a);
		return 8'(a * 17 + 1);
	endfunction
	task check(logic [63:0] seen, logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// bounded wait on one flag; a spent bound ends the run
	task automatic wait_for(int sel, logic lvl, int n);
		for (int k = 0; k < n && flags[sel] !== lvl; k++) begin
			@(posedge sys_clk_in);
			#1;
		end
		check(flags[sel], lvl);
		if (flags[sel] !== lvl) wrap_up();
	endtask
	// cold also pulls power-on reset, which allows a new load
	task power_up(logic cold);
		@(posedge sys_clk_in);
		reset_n_in <= 0;
		if (cold) por_n_in <= 0;
		repeat (16) @(posedge sys_clk_in);
		check({scl, sda_oe, st}, {2'b10, STATUS_RESET});
		reset_n_in <= 1;
		por_n_in <= 1;
	endtask
	task sw_read(logic [7:0] a);
		@(posedge sys_clk_in);
		req <= 1;
		waddr <= a;
		wait_for(0, 1, 100);
		@(posedge sys_clk_in);
		req <= 0;
		wait_for(1, 1, 50000);
	endtask
	initial begin
		power_up(1);
		repeat (8) @(posedge sys_clk_in);
		check({retry, st.loading}, 2'b11);
		wait_for(2, 1, 200000);
		repeat (2) @(posedge sys_clk_in);
		for (i = 1; i <= 8; i++) exp_uid = {exp_uid[55:0], img(i)};
		check(st, 4'h4);
		check(fmt, IMG_CARDBUS);
		check(uid, exp_uid);
		check(optrom, 6'(img(9)));
		check(card_info_structure, img(10));
		check(retry, 0);
		$display("test load done");
		wait_for(0, 0, 2000);
		// software reads, last word address as the boundary
		foreach (rows[r]) begin
			sw_read(rows[r].addr);
			check({nack, rdata}, {rows[r].nack, img(rows[r].addr)});
			// the bus must still be held free shortly before the idle time ends
			repeat (BUS_FREE_CYCLES - 10) @(posedge sys_clk_in);
			check(busy, 1'b1);
			wait_for(0, 0, 1000);
			$display("test read %h done", rows[r].addr);
		end
		// a bus reset alone must not reload
		power_up(0);
		repeat (3000) @(posedge sys_clk_in);
		check({st.loading, scl}, 2'b01);
		// clock enable low freezes the idle sequencer, so a request is not taken
		ce_in <= 0;
		req <= 1;
		repeat (20) @(posedge sys_clk_in);
		check({busy, scl, sda_oe}, 3'b010);
		req <= 0;
		ce_in <= 1;
		repeat (2) @(posedge sys_clk_in);
		check(busy, 1'b0);
		$display("test warm reset done");
		// empty socket found fast
		present <= 0;
		power_up(1);
		wait_for(2, 1, 30000);
		repeat (2) @(posedge sys_clk_in);
		check(st, 4'h7);
		check(uid, 64'h0);
		// a software read of the empty socket reports the nack
		wait_for(0, 0, 1000);
		sw_read(8'h3c);
		check({nack, rdata}, {1'b1, 8'hff});
		$display("test absent done");
		wrap_up();
	end
endmodule // testbench
bind serial_eeprom_loader loader_asserts chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
	.sw_busy_out(sw_busy_out), .sw_done_out(sw_done_out), .access_retry_out(access_retry_out),
	.load_status_out(load_status_out), .node_unique_identifier_out(node_unique_identifier_out),
	.option_rom_offset_field_out(option_rom_offset_field_out), .scl_out(scl_out),
	.sda_out(sda_out), .sda_oe_out(sda_oe_out));
